// >>> dv/mtio_pin_model.sv
// Purpose: pin-side surroundings of the timer/io block
// Assumes: every channel and pwm pin carries a pull-up; port pins see an outside source
// Notes: a released pin reads high, so open-drain release is visible
`timescale 1ns/1ns
module mtio_pin_model
	import mtio_pkg::*;
(
	input wire logic [9:0] da_out,
	input wire logic [9:0] da_oe,
	output logic [9:0] da_in,
	input wire logic [7:0] pwm_out,
	input wire logic [7:0] pwm_oe,
	output logic [7:0] pwm_in,
	input wire logic [15:0] pio_out,
	input wire logic [15:0] pio_oe,
	input wire logic [15:0] pio_ext,
	output logic [15:0] pio_in
);
	// driver wins where enabled, else the pull-up or outside source
	assign da_in = (da_oe & da_out) | ~da_oe;
	assign pwm_in = (pwm_oe & pwm_out) | ~pwm_oe;
	assign pio_in = (pio_oe & pio_out) | (~pio_oe & pio_ext);
endmodule : mtio_pin_model

// >>> dv/tb_modular_timer_io_subsystem.sv
// Purpose: register-level tests of the timer/io block
// Assumes: 50 MHz clock, reads answer one cycle after the strobe
// Notes: counter rates are checked as deltas over whole prescaler periods
`timescale 1ns/1ns
module tb_modular_timer_io_subsystem;
	import mtio_pkg::*;
	localparam logic [15:0] VER = 16'h3c3c; // arbitrary value
	logic clk = 0, rst = 1;
	mtio_req_t bus_req = '0;
	logic [15:0] rdata, pio_in, pio_out, pio_oe, v, v0;
	logic [1:0] cpin = 0, lpin = 0, irq_req;
	logic [9:0] da_in, da_out, da_oe;
	logic [7:0] pwm_in, pwm_out, pwm_oe;
	int fail_count = 0, n_compared = 0;
	mtio_top #(.VERSION(VER)) i_mtio_top(.clk(clk), .rst(rst),
		.bus_req(bus_req), .rdata(rdata), .counter_clock_pin(cpin),
		.counter_load_pin(lpin), .da_in(da_in), .da_out(da_out),
		.da_oe(da_oe), .pwm_in(pwm_in), .pwm_out(pwm_out),
		.pwm_oe(pwm_oe), .pio_in(pio_in), .pio_out(pio_out),
		.pio_oe(pio_oe), .irq_req(irq_req));
	mtio_pin_model i_mtio_pin_model(.da_out(da_out), .da_oe(da_oe),
		.da_in(da_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_in(pwm_in),
		.pio_out(pio_out), .pio_oe(pio_oe), .pio_ext(16'h5a5a),
		.pio_in(pio_in));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one idle cycle after each access keeps each strobe a single cycle
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = rdata;
		@(posedge clk);
	endtask : rd
	task automatic rc(input logic [11:0] a, input logic [15:0] e);
		rd(a, v);
		chk(v, e);
	endtask : rc
	// count steps of counter 0 over exactly k cycles
	task automatic delta(input int k, input logic [15:0] e);
		rd(12'h030, v0);
		repeat (k - 2) @(posedge clk);
		rd(12'h030, v);
		chk(v - v0, e);
	endtask : delta
	// drives the pins directly: an argument copy would never reach them
	task automatic pulse(input logic ld);
		if (ld) begin
			lpin[0] <= 1'b1;
		end else begin
			cpin[0] <= 1'b1;
		end
		repeat (4) @(posedge clk);
		cpin[0] <= 1'b0;
		lpin[0] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task automatic hold(input logic e);
		repeat (16) begin
			@(posedge clk);
			#1 chk(16'(pwm_out[0]), 16'(e));
		end
	endtask : hold
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	initial begin
		#(20 * 6000);
		fail_count++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wr(12'h800, 16'h0000);
		rc(12'h800, VER);
		rc(12'h810, 16'h0000);
		rc(12'h400, 16'h0000);
		wr(12'h0d8, 16'hbeef);
		rc(12'h0d8, 16'hbeef);
		// counter 0 internal, prescale 0, then each divide code
		wr(12'h034, 16'h0100);
		for (int d = 0; d < 16; d++) begin
			wr(12'h808, 16'(d));
			repeat (16) @(posedge clk); // let the old countdown run out
			delta(4 * ((d == 0) ? 16 : d + 1), 16'h0004);
		end
		wr(12'h808, 16'h4001);
		delta(16, 16'h0000);
		wr(12'h808, 16'h0001);
		// pin events, spaced eight cycles apart
		wr(12'h034, 16'h0200);
		wr(12'h030, 16'h0000);
		repeat (3) pulse(1'b0);
		rc(12'h030, 16'h0003);
		wr(12'h032, 16'h1234);
		pulse(1'b1);
		rc(12'h030, 16'h1234);
		// overflow from near the top with the request enabled
		wr(12'h030, 16'hfffe);
		wr(12'h034, 16'h0500);
		repeat (10) @(posedge clk);
		wr(12'h034, 16'h0400);
		rc(12'h034, 16'h8400);
		#1 chk(16'(irq_req), 16'h0001);
		rc(12'hc00, 16'h0100);
		rc(12'hc08, 16'h0000);
		wr(12'h034, 16'h8400);
		rc(12'h034, 16'h0400);
		#1 chk(16'(irq_req), 16'h0000);
		// channel 11 as output, totem-pole then open-drain
		wr(12'h058, 16'h0001);
		wr(12'h05c, 16'h0001);
		#1 chk(16'({da_oe[0], da_out[0]}), 16'h0003);
		wr(12'h05c, 16'h0021);
		rc(12'h05c, 16'h4021);
		wr(12'h058, 16'h0000);
		#1 chk(16'({da_oe[0], da_out[0]}), 16'h0002);
		rc(12'h05c, 16'h0021);
		// channel 11 capture: the pin rises as the driver lets go
		wr(12'h034, 16'h0800);
		wr(12'h030, 16'h00aa);
		wr(12'h05c, 16'h0002);
		@(posedge clk);
		rc(12'h058, 16'h00aa);
		rc(12'h05c, 16'hc002);
		// pwm 0: period 4, width 0, then full, then inverted
		wr(12'h000, 16'h0004);
		wr(12'h002, 16'h0000);
		wr(12'h006, 16'h0500);
		repeat (20) @(posedge clk);
		hold(1'b0);
		wr(12'h002, 16'h0004);
		repeat (20) @(posedge clk);
		hold(1'b1);
		chk(16'(pwm_oe[0]), 16'h0001);
		rd(12'h006, v);
		chk(v & 16'h8000, 16'h8000);
		wr(12'h006, 16'h0300);
		repeat (20) @(posedge clk);
		hold(1'b0);
		// port: low byte out, high byte in, then disabled
		wr(12'h102, 16'h00ff);
		wr(12'h100, 16'ha5c3);
		chk(pio_oe, 16'h00ff);
		rc(12'h100, 16'h5ac3);
		wr(12'h104, 16'h0001);
		wr(12'h100, 16'h0000);
		#1 chk(pio_out & 16'h00ff, 16'h00c3);
		close_out();
	end
endmodule : tb_modular_timer_io_subsystem

// >>> rtl/mtio_pkg.sv
// Purpose: shared constants, types and decode helpers for the timer/io block
// Assumes: 16-bit register words, byte addresses inside a 4 KB window
// Notes: a unit's registers start at its number times eight
package mtio_pkg;
	localparam int ADDR_W = 12; // four kilobyte window
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] BLK_MASK = 12'hff8;

	// one register access from the cpu side
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} mtio_req_t;

	// double-action channel modes, gray along the usual sequence
	typedef enum logic [2:0] {
		DA_PORT_IN = 3'h0,
		DA_PORT_OUT = 3'h1,
		DA_COMPARE = 3'h3,
		DA_CAPTURE = 3'h2,
		DA_PULSE = 3'h6,
		DA_PERIOD = 3'h7,
		DA_PWM = 3'h5
	} mtio_da_mode_t;

	typedef enum logic {ST_LEAD = 1'b0, ST_TRAIL = 1'b1} mtio_stage_t;

	// unit numbers are the block numbers of their first register block
	localparam logic [8:0] PWM_LO_NUM = 9'h000;
	localparam logic [8:0] MC_NUM0 = 9'h006;
	localparam logic [8:0] DA_LO_NUM = 9'h00b;
	localparam logic [8:0] PWM_HI_NUM = 9'h010;
	localparam logic [8:0] MC_NUM1 = 9'h016;
	localparam logic [8:0] DA_HI_NUM = 9'h01b;
	localparam logic [8:0] PIO_NUM = 9'h020;
	localparam logic [8:0] BIU_BLK = 9'h100;
	localparam logic [8:0] CPS_BLK = 9'h101;
	localparam logic [8:0] IRQ_BLK = 9'h180;

	// field positions
	localparam int FLAG_BIT = 15;
	localparam int CPS_DIS_BIT = 15;
	localparam int CPS_INH_BIT = 14;
	localparam int MC_CLK_LSB = 8;
	localparam int MC_IRQ_BIT = 10;
	localparam int MC_DRV_BIT = 11;
	localparam int MC_DIS_BIT = 12;
	localparam int DA_BUS_BIT = 3;
	localparam int DA_POL_BIT = 4;
	localparam int DA_OD_BIT = 5;
	localparam int DA_IRQ_BIT = 6;
	localparam int DA_DIS_BIT = 7;
	localparam int PW_EN_BIT = 8;
	localparam int PW_POL_BIT = 9;
	localparam int PW_IRQ_BIT = 10;
	localparam int PW_DIS_BIT = 11;
	localparam int PIO_DIS_BIT = 0;

	localparam logic [1:0] MC_CLK_INT = 2'h1;
	localparam logic [1:0] MC_CLK_PIN = 2'h2;
	localparam logic [15:0] CPS_WMASK = 16'hc00f;
	localparam logic [15:0] MC_WMASK = 16'h1fff;
	localparam logic [15:0] DA_WMASK = 16'h00ff;
	localparam logic [15:0] PW_WMASK = 16'h0fff;
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [1:0] MC_EXT_GAP = 2'h3; // pin counts 4 cycles apart

	function automatic logic [ADDR_W-1:0] unit_base(input logic [8:0] num);
		return {num, 3'b000};
	endfunction : unit_base

	function automatic logic blk_hit(input mtio_req_t r, input logic [8:0] n);
		return (r.addr & BLK_MASK) == unit_base(n);
	endfunction : blk_hit

	function automatic logic wr_hit(input mtio_req_t r, input logic [8:0] n,
		input logic [1:0] w);
		return r.wr && blk_hit(r, n) && r.addr[2:1] == w;
	endfunction : wr_hit

	function automatic logic [8:0] pwm_num(input int j);
		return (j < 4) ? PWM_LO_NUM + 9'(j) : PWM_HI_NUM + 9'(j - 4);
	endfunction : pwm_num

	function automatic logic [8:0] da_num(input int j);
		return (j < 5) ? DA_LO_NUM + 9'(j) : DA_HI_NUM + 9'(j - 5);
	endfunction : da_num

	function automatic logic [8:0] mc_num(input int j);
		return (j == 0) ? MC_NUM0 : MC_NUM1;
	endfunction : mc_num
endpackage : mtio_pkg

// >>> rtl/mtio_top.sv
// Purpose: modular timer and io block: prescaler, counters, channels, port
// Assumes: one 50 MHz clock, synchronous inputs, 16-bit register port
// Notes: read data stand only in the cycle after the read strobe
// Function
// - address space is blocks of four 16-bit registers, block 0 at base
// - a unit's number is the block number of its first block
// - unit register base is subsystem base plus eight times unit number
// - bus interface, prescaler unnumbered; interrupt units numbered from 0
// - the block decodes a four kilobyte range from its base
// - central prescaler 4-bit down-counter divides clock by 2 to 16
// - count-inhibit stops the central prescaler's counter clocks
// - modulus counter is 16-bit up-counter with own 8-bit prescaler
// - counter steps at most clk/2 internally, clk/4 from its pin
// - counter overflow sets a flag and, if enabled, an interrupt
// - a counter may drive its 16-bit shared counter bus
// - load pin edge loads the modulus value into the counter
// - counter can accumulate pin events with overflow flag
// - double-action channel handles two events, seven modes
// - each double-action channel picks one of two counter buses
// - channel has polarity, open-drain choice and readable pin state
// - pwm period and width are double-buffered, no glitches
// - pwm has own 8-bit prescaler, steps of at least 2 cycles
// - pwm runs alone, duty from constant low to constant high
// - pwm flags every period end and has selectable polarity
// - parallel port has 16 pins, direction per data direction bit
// - every unit but the bus interface and interrupt units has its own disable control
`timescale 1ns/1ns
module mtio_top
	import mtio_pkg::*;
#(
	parameter int N_MC = 2,
	parameter int N_DA = 10,
	parameter int N_PWM = 8,
	parameter logic [15:0] VERSION = 16'h0a51 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire mtio_req_t bus_req,
	output logic [DATA_W-1:0] rdata,
	input wire logic [N_MC-1:0] counter_clock_pin,
	input wire logic [N_MC-1:0] counter_load_pin,
	input wire logic [N_DA-1:0] da_in,
	output logic [N_DA-1:0] da_out,
	output logic [N_DA-1:0] da_oe,
	input wire logic [N_PWM-1:0] pwm_in,
	output logic [N_PWM-1:0] pwm_out,
	output logic [N_PWM-1:0] pwm_oe,
	input wire logic [15:0] pio_in,
	output logic [15:0] pio_out,
	output logic [15:0] pio_oe,
	output logic [1:0] irq_req
);
	logic [15:0] cps_ctl, next_cps_ctl;
	logic [3:0] cps_cnt, next_cps_cnt, cps_reload;
	logic cps_tick, next_cps_tick, cps_run;
	logic [15:0] mc_cnt [N_MC], next_mc_cnt [N_MC];
	logic [15:0] mc_mod [N_MC], next_mc_mod [N_MC];
	logic [15:0] mc_ctl [N_MC], next_mc_ctl [N_MC];
	logic [7:0] mc_pre [N_MC], next_mc_pre [N_MC];
	logic [1:0] mc_gap [N_MC], next_mc_gap [N_MC];
	logic [N_MC-1:0] mc_clk_q, mc_ld_q, mc_inc, mc_ext, mc_ld;
	logic [15:0] cbus [2];
	logic [15:0] da_a [N_DA], next_da_a [N_DA];
	logic [15:0] da_b [N_DA], next_da_b [N_DA];
	logic [15:0] da_ctl [N_DA], next_da_ctl [N_DA];
	logic [N_DA-1:0] da_lvl, next_da_lvl, da_q, da_stg, next_da_stg;
	logic [N_DA-1:0] next_da_out, next_da_oe, da_lead, da_trail;
	logic [15:0] pw_pb [N_PWM], next_pw_pb [N_PWM];
	logic [15:0] pw_wb [N_PWM], next_pw_wb [N_PWM];
	logic [15:0] pw_per [N_PWM], next_pw_per [N_PWM];
	logic [15:0] pw_wid [N_PWM], next_pw_wid [N_PWM];
	logic [15:0] pw_cnt [N_PWM], next_pw_cnt [N_PWM];
	logic [15:0] pw_ctl [N_PWM], next_pw_ctl [N_PWM];
	logic [7:0] pw_pre [N_PWM], next_pw_pre [N_PWM];
	logic [N_PWM-1:0] next_pwm_out, next_pwm_oe;
	logic [15:0] next_pio_out, next_pio_oe;
	logic pio_dis, next_pio_dis;
	logic [15:0] next_rdata, irq_pend0, irq_pend1;
	logic [1:0] next_irq;
	logic [1:0] wsel;

	assign wsel = bus_req.addr[2:1]; // word within a four-word block

	// central prescaler: reload value d gives d+1 cycles, code 0 means 16
	assign cps_reload = (cps_ctl[3:0] == 4'h0) ? 4'hf : cps_ctl[3:0];
	assign cps_run = !cps_ctl[CPS_INH_BIT] && !cps_ctl[CPS_DIS_BIT];
	always_comb begin
		next_cps_ctl = cps_ctl;
		if (wr_hit(bus_req, CPS_BLK, 2'h0))
			next_cps_ctl = bus_req.wdata & CPS_WMASK;
		next_cps_tick = 1'b0;
		if (!cps_run) begin
			next_cps_cnt = cps_reload; // inhibit or disable holds it at the reload value
		end else if (cps_cnt == 4'h0) begin
			next_cps_tick = 1'b1; // one pulse per N cycles
			next_cps_cnt = cps_reload;
		end else begin
			next_cps_cnt = cps_cnt - 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cps_ctl <= CTL_RST;
			cps_cnt <= 4'hf;
			cps_tick <= 1'b0;
		end else begin
			cps_ctl <= next_cps_ctl;
			cps_cnt <= next_cps_cnt;
			cps_tick <= next_cps_tick;
		end
	end

	// modulus counters; software writes to the counter win over counting
	always_comb begin
		next_mc_cnt = mc_cnt;
		next_mc_mod = mc_mod;
		next_mc_ctl = mc_ctl;
		next_mc_pre = mc_pre;
		next_mc_gap = mc_gap;
		mc_inc = '0;
		mc_ext = '0;
		mc_ld = counter_load_pin & ~mc_ld_q;
		for (int i = 0; i < N_MC; i++) begin
			if (wr_hit(bus_req, mc_num(i), 2'h2)) begin
				next_mc_ctl[i] = bus_req.wdata & MC_WMASK;
				next_mc_ctl[i][FLAG_BIT] = mc_ctl[i][FLAG_BIT] &&
					!bus_req.wdata[FLAG_BIT];
			end
			if (mc_gap[i] != 2'h0)
				next_mc_gap[i] = mc_gap[i] - 2'h1;
			if (!mc_ctl[i][MC_DIS_BIT]) begin
				case (mc_ctl[i][MC_CLK_LSB+1:MC_CLK_LSB])
					MC_CLK_INT: begin // 8-bit prescaler on central tick
						if (cps_tick && mc_pre[i] == 8'h00) begin
							mc_inc[i] = 1'b1; // tick spacing keeps it at clk/2
							next_mc_pre[i] = mc_ctl[i][7:0];
						end else if (cps_tick) begin
							next_mc_pre[i] = mc_pre[i] - 8'h01;
						end
					end
					MC_CLK_PIN: begin // pulse accumulator, clk/4 at most
						if (counter_clock_pin[i] && !mc_clk_q[i] &&
							mc_gap[i] == 2'h0) begin
							mc_inc[i] = 1'b1;
							mc_ext[i] = 1'b1;
							next_mc_gap[i] = MC_EXT_GAP;
						end
					end
					default: ;
				endcase
				if (mc_ld[i]) begin
					next_mc_cnt[i] = mc_mod[i]; // external load
				end else if (mc_inc[i] && mc_cnt[i] == 16'hffff) begin
					next_mc_cnt[i] = mc_mod[i];
					next_mc_ctl[i][FLAG_BIT] = 1'b1; // set beats clear
				end else if (mc_inc[i]) begin
					next_mc_cnt[i] = mc_cnt[i] + 16'h0001;
				end
			end
			if (wr_hit(bus_req, mc_num(i), 2'h0))
				next_mc_cnt[i] = bus_req.wdata;
			if (wr_hit(bus_req, mc_num(i), 2'h1))
				next_mc_mod[i] = bus_req.wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			mc_cnt <= '{default: 16'h0000};
			mc_mod <= '{default: 16'h0000};
			mc_ctl <= '{default: CTL_RST};
			mc_pre <= '{default: 8'h00};
			mc_gap <= '{default: 2'h0};
			mc_clk_q <= '0;
			mc_ld_q <= '0;
		end else begin
			mc_cnt <= next_mc_cnt;
			mc_mod <= next_mc_mod;
			mc_ctl <= next_mc_ctl;
			mc_pre <= next_mc_pre;
			mc_gap <= next_mc_gap;
			mc_clk_q <= counter_clock_pin;
			mc_ld_q <= counter_load_pin;
		end
	end

	// shared counter buses read zero when their counter does not drive
	always_comb begin
		for (int k = 0; k < 2; k++)
			cbus[k] = mc_ctl[k][MC_DRV_BIT] ? mc_cnt[k] : 16'h0000;
	end

	// double-action channels; polarity picks the leading edge of inputs
	always_comb begin
		next_da_a = da_a;
		next_da_b = da_b;
		next_da_ctl = da_ctl;
		next_da_lvl = da_lvl;
		next_da_stg = da_stg;
		next_da_out = '0;
		next_da_oe = '0;
		da_lead = '0;
		da_trail = '0;
		for (int i = 0; i < N_DA; i++) begin
			da_lead[i] = da_ctl[i][DA_POL_BIT] ? (da_q[i] && !da_in[i]) :
				(!da_q[i] && da_in[i]);
			da_trail[i] = da_ctl[i][DA_POL_BIT] ? (!da_q[i] && da_in[i]) :
				(da_q[i] && !da_in[i]);
			if (wr_hit(bus_req, da_num(i), 2'h2)) begin
				next_da_ctl[i] = bus_req.wdata & DA_WMASK;
				next_da_ctl[i][FLAG_BIT] = da_ctl[i][FLAG_BIT] &&
					!bus_req.wdata[FLAG_BIT];
			end
			if (wr_hit(bus_req, da_num(i), 2'h0))
				next_da_a[i] = bus_req.wdata;
			if (wr_hit(bus_req, da_num(i), 2'h1))
				next_da_b[i] = bus_req.wdata;
			if (!da_ctl[i][DA_DIS_BIT]) begin
				// two events, A then B, complete before software must act
				case (mtio_da_mode_t'(da_ctl[i][2:0]))
					DA_PORT_OUT: next_da_lvl[i] = da_a[i][0];
					DA_CAPTURE: if (da_lead[i]) begin
						next_da_a[i] = cbus[da_ctl[i][DA_BUS_BIT]];
						next_da_ctl[i][FLAG_BIT] = 1'b1;
					end
					DA_COMPARE, DA_PWM: begin
						if (cbus[da_ctl[i][DA_BUS_BIT]] == da_a[i])
							next_da_lvl[i] = 1'b1;
						if (cbus[da_ctl[i][DA_BUS_BIT]] == da_b[i]) begin
							next_da_lvl[i] = 1'b0;
							next_da_ctl[i][FLAG_BIT] = 1'b1;
						end
					end
					DA_PULSE, DA_PERIOD: begin
						if (da_stg[i] == ST_LEAD && da_lead[i]) begin
							next_da_a[i] = cbus[da_ctl[i][DA_BUS_BIT]];
							next_da_stg[i] = ST_TRAIL;
						end else if (da_stg[i] == ST_TRAIL &&
							(da_ctl[i][0] ? da_lead[i] : da_trail[i])) begin
							next_da_b[i] = cbus[da_ctl[i][DA_BUS_BIT]];
							next_da_ctl[i][FLAG_BIT] = 1'b1;
							next_da_stg[i] = ST_LEAD;
						end
					end
					default: next_da_stg[i] = ST_LEAD;
				endcase
			end
			// open drain only ever pulls low
			next_da_out[i] = !da_ctl[i][DA_OD_BIT] &&
				(next_da_lvl[i] ^ da_ctl[i][DA_POL_BIT]);
			next_da_oe[i] = (da_ctl[i][2:0] == DA_PORT_OUT ||
				da_ctl[i][2:0] == DA_COMPARE || da_ctl[i][2:0] == DA_PWM) &&
				(!da_ctl[i][DA_OD_BIT] ||
				!(next_da_lvl[i] ^ da_ctl[i][DA_POL_BIT]));
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			da_a <= '{default: 16'h0000};
			da_b <= '{default: 16'h0000};
			da_ctl <= '{default: CTL_RST};
			da_lvl <= '0;
			da_stg <= '0;
			da_q <= '0;
			da_out <= '0;
			da_oe <= '0;
		end else begin
			da_a <= next_da_a;
			da_b <= next_da_b;
			da_ctl <= next_da_ctl;
			da_lvl <= next_da_lvl;
			da_stg <= next_da_stg;
			da_q <= da_in;
			da_out <= next_da_out;
			da_oe <= next_da_oe;
		end
	end

	// pwm channels: buffers copy to active values at a period end, or at once while neither enabled nor disabled
	always_comb begin
		next_pw_pb = pw_pb;
		next_pw_wb = pw_wb;
		next_pw_per = pw_per;
		next_pw_wid = pw_wid;
		next_pw_cnt = pw_cnt;
		next_pw_ctl = pw_ctl;
		next_pw_pre = pw_pre;
		next_pwm_out = '0;
		next_pwm_oe = '0;
		for (int j = 0; j < N_PWM; j++) begin
			if (wr_hit(bus_req, pwm_num(j), 2'h0))
				next_pw_pb[j] = bus_req.wdata;
			if (wr_hit(bus_req, pwm_num(j), 2'h1))
				next_pw_wb[j] = bus_req.wdata;
			if (wr_hit(bus_req, pwm_num(j), 2'h3)) begin
				next_pw_ctl[j] = bus_req.wdata & PW_WMASK;
				next_pw_ctl[j][FLAG_BIT] = pw_ctl[j][FLAG_BIT] &&
					!bus_req.wdata[FLAG_BIT];
			end
			if (pw_ctl[j][PW_DIS_BIT]) begin
				next_pw_cnt[j] = pw_cnt[j]; // frozen to save power
			end else if (!pw_ctl[j][PW_EN_BIT]) begin
				next_pw_cnt[j] = 16'h0000; // idle: buffers pass straight on
				next_pw_per[j] = pw_pb[j];
				next_pw_wid[j] = pw_wb[j];
				next_pw_pre[j] = pw_ctl[j][7:0];
			end else if (cps_tick) begin
				// own prescaler off the central tick, so steps are >= 2
				next_pw_pre[j] = pw_pre[j] - 8'h01;
				if (pw_pre[j] == 8'h00) begin
					next_pw_pre[j] = pw_ctl[j][7:0];
					if (pw_cnt[j] + 16'h0001 >= pw_per[j]) begin
						next_pw_cnt[j] = 16'h0000;
						next_pw_per[j] = pw_pb[j]; // glitch-free update
						next_pw_wid[j] = pw_wb[j];
						next_pw_ctl[j][FLAG_BIT] = 1'b1; // period end
					end else begin
						next_pw_cnt[j] = pw_cnt[j] + 16'h0001;
					end
				end
			end
			// with polarity bit clear, width 0 holds low, width >= period holds high
			next_pwm_out[j] = (pw_ctl[j][PW_EN_BIT] &&
				next_pw_cnt[j] < next_pw_wid[j]) ^ pw_ctl[j][PW_POL_BIT];
			next_pwm_oe[j] = pw_ctl[j][PW_EN_BIT];
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pw_pb <= '{default: 16'h0000};
			pw_wb <= '{default: 16'h0000};
			pw_per <= '{default: 16'h0000};
			pw_wid <= '{default: 16'h0000};
			pw_cnt <= '{default: 16'h0000};
			pw_ctl <= '{default: CTL_RST};
			pw_pre <= '{default: 8'h00};
			pwm_out <= '0;
			pwm_oe <= '0;
		end else begin
			pw_pb <= next_pw_pb;
			pw_wb <= next_pw_wb;
			pw_per <= next_pw_per;
			pw_wid <= next_pw_wid;
			pw_cnt <= next_pw_cnt;
			pw_ctl <= next_pw_ctl;
			pw_pre <= next_pw_pre;
			pwm_out <= next_pwm_out;
			pwm_oe <= next_pwm_oe;
		end
	end

	// parallel port; a disabled port ignores data and direction writes
	always_comb begin
		next_pio_out = pio_out;
		next_pio_oe = pio_oe;
		next_pio_dis = pio_dis;
		if (wr_hit(bus_req, PIO_NUM, 2'h2))
			next_pio_dis = bus_req.wdata[PIO_DIS_BIT];
		if (!pio_dis && wr_hit(bus_req, PIO_NUM, 2'h0))
			next_pio_out = bus_req.wdata;
		if (!pio_dis && wr_hit(bus_req, PIO_NUM, 2'h1))
			next_pio_oe = bus_req.wdata; // one direction bit per pin
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pio_out <= 16'h0000;
			pio_oe <= 16'h0000;
			pio_dis <= 1'b0;
		end else begin
			pio_out <= next_pio_out;
			pio_oe <= next_pio_oe;
			pio_dis <= next_pio_dis;
		end
	end

	// read mux and interrupt-request units 0 and 1; unmapped words read 0
	always_comb begin
		irq_pend0 = 16'h0000;
		irq_pend1 = 16'h0000;
		for (int j = 0; j < N_PWM; j++)
			irq_pend0[j] = pw_ctl[j][FLAG_BIT] && pw_ctl[j][PW_IRQ_BIT];
		for (int i = 0; i < N_MC; i++)
			irq_pend0[8+i] = mc_ctl[i][FLAG_BIT] && mc_ctl[i][MC_IRQ_BIT];
		for (int i = 0; i < N_DA; i++)
			irq_pend1[i] = da_ctl[i][FLAG_BIT] && da_ctl[i][DA_IRQ_BIT];
		next_irq = {|irq_pend1, |irq_pend0}; // unit number n is bit n
		next_rdata = 16'h0000;
		if (bus_req.rd) begin // address bits 11 to 1 decoded, bit 0 ignored
			if (blk_hit(bus_req, BIU_BLK) && wsel == 2'h0)
				next_rdata = VERSION;
			if (blk_hit(bus_req, CPS_BLK) && wsel == 2'h0)
				next_rdata = cps_ctl;
			for (int k = 0; k < 2; k++)
				if (blk_hit(bus_req, IRQ_BLK + 9'(k)) && wsel == 2'h0)
					next_rdata = (k == 0) ? irq_pend0 : irq_pend1;
			for (int i = 0; i < N_MC; i++)
				if (blk_hit(bus_req, mc_num(i)))
					case (wsel)
						2'h0: next_rdata = mc_cnt[i];
						2'h1: next_rdata = mc_mod[i];
						2'h2: next_rdata = {mc_ctl[i][15], counter_clock_pin[i],
							mc_ctl[i][13:0]};
						default: next_rdata = 16'h0000;
					endcase
			for (int i = 0; i < N_DA; i++)
				if (blk_hit(bus_req, da_num(i)))
					case (wsel)
						2'h0: next_rdata = da_a[i];
						2'h1: next_rdata = da_b[i];
						2'h2: next_rdata = {da_ctl[i][15], da_in[i],
							da_ctl[i][13:0]}; // pin state readable
						default: next_rdata = 16'h0000;
					endcase
			for (int j = 0; j < N_PWM; j++)
				if (blk_hit(bus_req, pwm_num(j)))
					case (wsel)
						2'h0: next_rdata = pw_pb[j];
						2'h1: next_rdata = pw_wb[j];
						2'h2: next_rdata = pw_cnt[j];
						default: next_rdata = {pw_ctl[j][15], pwm_in[j],
							pw_ctl[j][13:0]};
					endcase
			if (blk_hit(bus_req, PIO_NUM))
				case (wsel)
					2'h0: next_rdata = (pio_oe & pio_out) | (~pio_oe & pio_in);
					2'h1: next_rdata = pio_oe;
					2'h2: next_rdata = {15'h0000, pio_dis};
					default: next_rdata = 16'h0000;
				endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 16'h0000;
			irq_req <= 2'h0;
		end else begin
			rdata <= next_rdata;
			irq_req <= next_irq;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_tick_gap: assert property (
		cps_tick |=> !cps_tick) else $error("prescaler ticks back to back");
	chk_tick_ratio: assert property (
		(cps_tick && cps_run && cps_cnt == 4'h2 &&
		cps_reload == 4'h2) ##1
		(cps_run && cps_reload == 4'h2)[*2] |=> cps_tick)
		else $error("prescaler ratio 3 missed a tick");
	chk_inhibit_stop: assert property (
		!cps_run |=> !cps_tick) else $error("tick while inhibited");
	chk_mc_overflow: assert property (
		mc_inc[0] && mc_cnt[0] == 16'hffff && !mc_ld[0] && !bus_req.wr
		|=> mc_ctl[0][FLAG_BIT] && mc_cnt[0] == $past(mc_mod[0]))
		else $error("overflow did not reload and flag");
	chk_mc_ext_rate: assert property (
		mc_ext[0] |=> !mc_ext[0] [*3]) else $error("pin count too fast");
	chk_mc_load: assert property (
		mc_ld[0] && !mc_ctl[0][MC_DIS_BIT] && !bus_req.wr
		|=> mc_cnt[0] == $past(mc_mod[0])) else $error("load pin ignored");
	chk_da_capture: assert property (
		da_ctl[0][2:0] == DA_CAPTURE && !da_ctl[0][DA_DIS_BIT] && da_lead[0]
		&& !bus_req.wr |=> da_a[0] == $past(cbus[da_ctl[0][DA_BUS_BIT]])
		&& da_ctl[0][FLAG_BIT]) else $error("capture lost");
	chk_pwm_buffer: assert property (
		!$stable(pw_per[0]) && $past(pw_ctl[0][PW_EN_BIT])
		&& pw_ctl[0][PW_EN_BIT] |-> pw_cnt[0] == 16'h0000)
		else $error("period changed mid-cycle");
	chk_pwm_low: assert property (
		pw_ctl[0][PW_EN_BIT] && !pw_ctl[0][PW_POL_BIT] && pw_wid[0] == 0
		&& $stable(pw_ctl[0]) && $stable(pw_wid[0]) |-> !pwm_out[0])
		else $error("zero width pwm went high");
	chk_pio_dir: assert property (
		wr_hit(bus_req, PIO_NUM, 2'h1) && !pio_dis
		|=> pio_oe == $past(bus_req.wdata)) else $error("direction not set");
	chk_read_gap: assert property (
		bus_req.rd && (bus_req.addr & BLK_MASK) == 12'h400
		|=> rdata == 16'h0000) else $error("unmapped read not zero");
	cov_mc_wrap: cover property (mc_inc[0] && mc_cnt[0] == 16'hffff);
	cov_pwm_end: cover property (pw_ctl[0][PW_EN_BIT] && $rose(pw_ctl[0][15]));
	cov_da_pulse: cover property (da_stg[0] ##[1:50] !da_stg[0]);
endmodule : mtio_top
